// file: ring_mac_map.vh
`ifndef RING_MAC_MAP_VH
`define RING_MAC_MAP_VH
// register indices on the plain port
`define REG_MODE_ONE      4'h0
`define REG_STATUS        4'h1
`define REG_MAX_ROT       4'h2
`define REG_TRT_DEF       4'h3
`define REG_THT_DEF       4'h4
`define REG_TVX_DEF       4'h5
`define REG_TRT_LOAD      4'h6
`define REG_THT_LOAD      4'h7
`define REG_TVX_LOAD      4'h8
`define REG_ADDR_LO       4'h9
`define REG_ADDR_HI       4'ha
`define REG_TX_CTRL       4'hb
// mode register one fields
`define MACHINE_MODE_FIELD_HI          14
`define MACHINE_MODE_FIELD_LO          12
`define MODE_INIT         3'h0
`define MODE_MEM_ACTIVE   3'h1
`define MODE_ON_LINE      3'h2
`define MODE_ON_LINE_SPEC 3'h3
`define MODE_LOOP_INT     3'h4
`define MODE_LOOP_EXT     3'h5
`define MODE_RST          16'h0000
// reset and default values of the timers
`define TRT_RESET         21'h000000
`define THT_RESET         16'hffff
`define TVX_RESET         8'hff
`define TRT_DEF_RESET     21'h1fffff
`define THT_DEF_RESET     16'hffff
`define TVX_DEF_RESET     8'hff
`define MAX_ROT_RESET     21'h1fffff
// framing
`define IDLE_GAP          5'd16
`define PREAMBLE_BYTES    5'd16
// symbol pair codes on the byte path
`define SYM_IDLE          8'hff
`define SYM_JK            8'hc5
`define SYM_TT            8'h77
`define SYM_TS            8'h7a
`define SYM_RR            8'h55
`define SYM_SS            8'haa
`define SYM_RS            8'h5a
`define SYM_SR            8'ha5
`define SYM_TOKEN_FC      8'h80
`endif

// file: crc32_byte.v
`include "ring_mac_map.vh"
// one byte per cycle crc, reflected, residue inverted on output
module crc32_byte (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        clear_in,
  input  wire        enable_in,
  input  wire [7:0]  data_in,
  output wire [31:0] fcs_out
);
  reg  [31:0] crc;
  reg  [31:0] next_crc;
  integer     i;
  // bitwise update, lsb first as on the ring
  always @* begin
    next_crc = crc;
    for (i = 0; i < 8; i = i + 1) begin
      if (next_crc[0] ^ data_in[i])
        next_crc = (next_crc >> 1) ^ 32'hedb88320;
      else
        next_crc = next_crc >> 1;
    end
  end
  always @(posedge clk_in) begin
    if (rst_in || clear_in)
      crc <= 32'hffffffff;
    else if (enable_in)
      crc <= next_crc;
  end
  assign fcs_out = ~crc;
endmodule // crc32_byte

// file: ring_mac_tx_path_mode_ctrl.v
`include "ring_mac_map.vh"
// Summary of operation
// - split each fifo word into four bytes
// - parity bits steer symbols, never transmitted
// - send local bytes or repeat received stream
// - stop repeating own or defective frames
// - append 32-bit crc, separate from receive
// - emit idles, jk, t, e a c, tokens
// - protocol machine above symbol machine, status
// - at least sixteen idles between frames
// - six modes chosen in mode register one
// - online special leaves a and c reset
// - zero mode field or reset gives init
// - init holds transmit and receive in reset
// - init blind repeats receive bus to output
// - station address writable only in init
// - timer defaults writable in any mode
// - timers keep running during init
// - valid transmission timer expires, then stops
// - rotation cleared, holding set all ones
// - rotation timer reloads max limit on expiry
// - direct writes reload and restart counters
// - leaving init loads timer defaults
// - memory active receives nothing, ignores claims
// - online left on mode change or reset
module ring_mac_tx_path_mode_ctrl (
  input  wire        sys_clk_in,
  input  wire        rst_in,
  input  wire [3:0]  addr_in,
  input  wire [15:0] wr_data_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [15:0] rd_data_out,
  input  wire [35:0] tx_word_in,
  input  wire        tx_word_valid_in,
  output reg         tx_word_take_out,
  input  wire        tx_frame_last_in,
  input  wire        tx_token_req_in,
  input  wire        tx_restricted_in,
  input  wire        bus_select_in,
  input  wire [7:0]  receive_bus_a_in,
  input  wire [7:0]  receive_bus_b_in,
  input  wire        rx_repeat_in,
  input  wire        rx_strip_in,
  input  wire        rx_ext_copy_in,
  input  wire        rx_error_in,
  output reg  [7:0]  tx_byte_out,
  output reg         tx_active_out,
  output reg         rx_enable_out,
  output reg         claim_beacon_enable_out,
  output reg  [2:0]  mode_out
);
  // protocol machine states
  localparam [1:0] P_IDLE = 2'h0, P_TX = 2'h1, P_REPEAT = 2'h2, P_GAP = 2'h3;
  // symbol machine states
  localparam [2:0] S_PRE = 3'h0, S_SD = 3'h1, S_DATA = 3'h2, S_FCS = 3'h3,
                   S_ED = 3'h4, S_FS = 3'h5, S_TOK_FC = 3'h6, S_TOK_ED = 3'h7;

  reg  [15:0] mode_reg;
  reg  [2:0]  mode_prev;
  reg  [20:0] max_rot;
  reg  [20:0] trt_def;
  reg  [15:0] tht_def;
  reg  [7:0]  tvx_def;
  reg  [20:0] token_rotation_timer;
  reg  [15:0] token_holding_timer;
  reg  [7:0]  valid_transmission_timer;
  reg         trt_exp;
  reg         tht_exp;
  reg         tvx_exp;
  reg  [31:0] station_addr;
  reg  [1:0]  pstate;
  reg  [2:0]  sstate;
  reg  [4:0]  cnt;
  reg  [1:0]  lane;
  reg  [35:0] word;
  reg         word_last;
  reg         is_token;
  reg         tx_done;
  reg         restricted;
  reg  [7:0]  next_byte;
  reg  [7:0]  rx_byte;
  wire        in_init;
  wire        leave_init;
  wire [31:0] fcs;
  wire        crc_clear;
  wire        crc_en;
  wire [7:0]  local_byte;
  wire        special_lane;

  assign in_init    = (mode_reg[`MACHINE_MODE_FIELD_HI:`MACHINE_MODE_FIELD_LO] == `MODE_INIT);
  assign leave_init = (mode_prev == `MODE_INIT) && !in_init;
  // byte lane select, most significant byte goes first
  assign local_byte = word[8*(3-lane) +: 8];
  // parity bit of the current lane marks a special symbol request
  assign special_lane = word[32 + 3 - lane];
  assign crc_clear = (sstate == S_SD);
  assign crc_en    = (sstate == S_DATA) && (pstate == P_TX);

  // separate crc on the transmit path only
  crc32_byte u_crc (
    .clk_in    (sys_clk_in),
    .rst_in    (rst_in),
    .clear_in  (crc_clear),
    .enable_in (crc_en),
    .data_in   (local_byte),
    .fcs_out   (fcs)
  );

  // register writes; the mode field applies at the clock edge, whole bytes
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      mode_reg     <= `MODE_RST;
      max_rot      <= `MAX_ROT_RESET;
      trt_def      <= `TRT_DEF_RESET;
      tht_def      <= `THT_DEF_RESET;
      tvx_def      <= `TVX_DEF_RESET;
      station_addr <= 32'h00000000;
      restricted   <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == `REG_MODE_ONE)
        mode_reg <= wr_data_in;
      else if (addr_in == `REG_MAX_ROT)
        max_rot <= {wr_data_in, 5'h00};
      else if (addr_in == `REG_TRT_DEF)
        trt_def <= {wr_data_in, 5'h00};
      else if (addr_in == `REG_THT_DEF)
        tht_def <= wr_data_in;
      else if (addr_in == `REG_TVX_DEF)
        tvx_def <= wr_data_in[7:0];
      else if (addr_in == `REG_ADDR_LO && in_init)
        station_addr[15:0] <= wr_data_in;
      else if (addr_in == `REG_ADDR_HI && in_init)
        station_addr[31:16] <= wr_data_in;
      else if (addr_in == `REG_TX_CTRL)
        restricted <= wr_data_in[0];
    end
  end

  // previous mode, used to see the exit from init
  always @(posedge sys_clk_in) begin
    if (rst_in)
      mode_prev <= `MODE_INIT;
    else
      mode_prev <= mode_reg[`MACHINE_MODE_FIELD_HI:`MACHINE_MODE_FIELD_LO];
  end

  // timers run in every mode, including init
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      token_rotation_timer     <= 21'h00000;
      token_holding_timer     <= `THT_RESET;
      valid_transmission_timer     <= `TVX_RESET;
      trt_exp <= 1'b0;
      tht_exp <= 1'b0;
      tvx_exp <= 1'b0;
    end else begin
      // rotation timer counts up, expiry reloads the limit
      if (leave_init || (wr_in && addr_in == `REG_TRT_LOAD)) begin
        token_rotation_timer <= leave_init ? trt_def : {wr_data_in, 5'h00};
      end else if (token_rotation_timer == 21'h1fffff) begin
        token_rotation_timer     <= max_rot;
        trt_exp <= 1'b1;
      end else begin
        token_rotation_timer <= token_rotation_timer + 21'h000001;
      end
      // holding timer counts up and stops at terminal count
      if (leave_init || (wr_in && addr_in == `REG_THT_LOAD)) begin
        token_holding_timer     <= leave_init ? tht_def : wr_data_in;
        tht_exp <= 1'b0;
      end else if (token_holding_timer == 16'hffff) begin
        tht_exp <= 1'b1;
      end else begin
        token_holding_timer <= token_holding_timer + 16'h0001;
      end
      // valid transmission timer counts down from 255 and holds at zero
      if (leave_init || (wr_in && addr_in == `REG_TVX_LOAD)) begin
        valid_transmission_timer     <= leave_init ? tvx_def : wr_data_in[7:0];
        tvx_exp <= 1'b0;
      end else if (valid_transmission_timer == 8'h00) begin
        tvx_exp <= 1'b1;
      end else begin
        valid_transmission_timer <= valid_transmission_timer - 8'h01;
      end
    end
  end

  // select the repeat source once per byte
  always @* begin
    rx_byte = bus_select_in ? receive_bus_b_in : receive_bus_a_in;
  end

  // protocol and symbol machines, held in reset while in init
  always @(posedge sys_clk_in) begin
    if (rst_in || in_init) begin
      pstate           <= P_IDLE;
      sstate           <= S_PRE;
      cnt              <= 5'd0;
      lane             <= 2'd0;
      word             <= 36'h000000000;
      word_last        <= 1'b0;
      is_token         <= 1'b0;
      tx_done          <= 1'b0;
      tx_word_take_out <= 1'b0;
    end else begin
      tx_word_take_out <= 1'b0;
      case (pstate)
        P_IDLE: begin
          cnt <= 5'd0;
          if (mode_reg[`MACHINE_MODE_FIELD_HI:`MACHINE_MODE_FIELD_LO] != `MODE_MEM_ACTIVE &&
              (tx_token_req_in || tx_word_valid_in)) begin
            pstate   <= P_TX;
            sstate   <= S_PRE;
            is_token <= tx_token_req_in && !tx_word_valid_in;
            tx_done  <= 1'b0;
          end else if (rx_repeat_in) begin
            pstate <= P_REPEAT;
          end
        end
        P_REPEAT: begin
          if (rx_strip_in || rx_error_in || !rx_repeat_in)
            pstate <= P_GAP;
        end
        P_TX: begin
          case (sstate)
            S_PRE: begin
              cnt <= cnt + 5'd1;
              if (cnt == `PREAMBLE_BYTES - 5'd1) begin
                cnt    <= 5'd0;
                sstate <= S_SD;
              end
            end
            S_SD: begin
              sstate <= is_token ? S_TOK_FC : S_DATA;
              if (!is_token) begin
                word             <= tx_word_in;
                word_last        <= tx_frame_last_in;
                tx_word_take_out <= 1'b1;
                lane             <= 2'd0;
              end
            end
            S_DATA: begin
              lane <= lane + 2'd1;
              if (lane == 2'd3) begin
                if (word_last) begin
                  sstate <= S_FCS;
                  cnt    <= 5'd0;
                end else if (tx_word_valid_in) begin
                  word             <= tx_word_in;
                  word_last        <= tx_frame_last_in;
                  tx_word_take_out <= 1'b1;
                end
              end
            end
            S_FCS: begin
              cnt <= cnt + 5'd1;
              if (cnt == 5'd3) begin
                cnt    <= 5'd0;
                sstate <= S_ED;
              end
            end
            S_ED: sstate <= S_FS;
            S_FS: begin
              pstate  <= P_GAP;
              tx_done <= 1'b1;
            end
            S_TOK_FC: sstate <= S_TOK_ED;
            default: begin
              pstate  <= P_GAP;
              tx_done <= 1'b1;
            end
          endcase
        end
        default: begin
          // interframe idles before the next frame may start
          cnt <= cnt + 5'd1;
          if (cnt == `IDLE_GAP - 5'd1) begin
            cnt    <= 5'd0;
            pstate <= P_IDLE;
          end
        end
      endcase
    end
  end

  // output byte: blind repeat in init, else per machine state
  always @* begin
    next_byte = `SYM_IDLE;
    if (in_init) begin
      next_byte = rx_byte;
    end else if (pstate == P_REPEAT) begin
      next_byte = rx_byte;
    end else if (pstate == P_TX) begin
      case (sstate)
        S_PRE:    next_byte = `SYM_IDLE;
        S_SD:     next_byte = `SYM_JK;
        S_DATA:   next_byte = special_lane ? `SYM_IDLE : local_byte;
        S_FCS:    next_byte = fcs[8*(3-cnt[1:0]) +: 8];
        S_ED:     next_byte = `SYM_TS;
        S_FS: begin
          // online special never sets a or c on an external copy
          if (mode_reg[`MACHINE_MODE_FIELD_HI:`MACHINE_MODE_FIELD_LO] == `MODE_ON_LINE_SPEC &&
              rx_ext_copy_in)
            next_byte = `SYM_RR;
          else
            next_byte = rx_ext_copy_in ? `SYM_SS : `SYM_RR;
        end
        S_TOK_FC: next_byte = (restricted || tx_restricted_in) ?
                              8'hc0 : `SYM_TOKEN_FC;
        default:  next_byte = `SYM_TT;
      endcase
    end
  end

  // registered outputs and mode gating of receive functions
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      tx_byte_out             <= `SYM_IDLE;
      tx_active_out           <= 1'b0;
      rx_enable_out           <= 1'b0;
      claim_beacon_enable_out <= 1'b0;
      mode_out                <= `MODE_INIT;
    end else begin
      tx_byte_out   <= next_byte;
      tx_active_out <= (pstate == P_TX);
      mode_out      <= mode_reg[`MACHINE_MODE_FIELD_HI:`MACHINE_MODE_FIELD_LO];
      // no reception in init or memory active
      rx_enable_out <= !in_init &&
        mode_reg[`MACHINE_MODE_FIELD_HI:`MACHINE_MODE_FIELD_LO] != `MODE_MEM_ACTIVE;
      claim_beacon_enable_out <= !in_init &&
        mode_reg[`MACHINE_MODE_FIELD_HI:`MACHINE_MODE_FIELD_LO] != `MODE_MEM_ACTIVE;
    end
  end

  // read port, data one cycle after the strobe, unmapped reads zero
  always @(posedge sys_clk_in) begin
    if (rst_in)
      rd_data_out <= 16'h0000;
    else if (rd_in) begin
      if (addr_in == `REG_MODE_ONE)
        rd_data_out <= mode_reg;
      else if (addr_in == `REG_STATUS)
        rd_data_out <= {10'h000, tx_done, pstate == P_TX,
                        in_init, trt_exp, tht_exp, tvx_exp};
      else if (addr_in == `REG_MAX_ROT)
        rd_data_out <= max_rot[20:5];
      else if (addr_in == `REG_TRT_LOAD)
        rd_data_out <= token_rotation_timer[20:5];
      else if (addr_in == `REG_THT_LOAD)
        rd_data_out <= token_holding_timer;
      else if (addr_in == `REG_TVX_LOAD)
        rd_data_out <= {8'h00, valid_transmission_timer};
      else if (addr_in == `REG_ADDR_LO)
        rd_data_out <= station_addr[15:0];
      else if (addr_in == `REG_ADDR_HI)
        rd_data_out <= station_addr[31:16];
      else
        rd_data_out <= 16'h0000;
    end else
      rd_data_out <= 16'h0000;
  end
endmodule // ring_mac_tx_path_mode_ctrl

// file: ring_mac_chk.sv
// watches the top ports of the transmit path and mode control
module ring_mac_chk (
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic [3:0]  addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic        wr_in,
  input wire logic        bus_select_in,
  input wire logic [7:0]  receive_bus_a_in,
  input wire logic [7:0]  receive_bus_b_in,
  input wire logic [7:0]  tx_byte_out,
  input wire logic        tx_active_out,
  input wire logic        tx_word_take_out,
  input wire logic        rx_enable_out,
  input wire logic        claim_beacon_enable_out,
  input wire logic [2:0]  mode_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // mode field of a write, sliced so $past sees a plain signal
  wire [2:0] mfield = wr_data_in[14:12];
  wire [7:0] rx_sel = bus_select_in ? receive_bus_b_in : receive_bus_a_in;

  property p_rst_init;
    $fell(rst_in) |-> mode_out == 3'h0 && tx_byte_out == 8'hff;
  endproperty
  a_rst_init: assert property (p_rst_init)
    else $error("reset did not give init mode");

  // needs two init cycles: the cycle of entry still shows old logic
  property p_blind;
    mode_out == 3'h0 && $past(mode_out) == 3'h0 |=>
      mode_out != 3'h0 || tx_byte_out == $past(rx_sel);
  endproperty
  a_blind: assert property (p_blind)
    else $error("init output is not the selected receive bus");

  property p_take_gap;
    tx_word_take_out |=> !tx_word_take_out [*3];
  endproperty
  a_take_gap: assert property (p_take_gap)
    else $error("word taken before four bytes were sent");

  property p_preamble;
    $rose(tx_active_out) |->
      (tx_byte_out == 8'hff) [*8] ##1 (tx_byte_out == 8'hff) [*7];
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("too few idle bytes before a start delimiter");

  property p_init_quiet;
    mode_out == 3'h0 && $past(mode_out) == 3'h0 |->
      !tx_active_out && !tx_word_take_out;
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("transmit machine active in init mode");

  property p_rx_off;
    mode_out <= 3'h1 && $stable(mode_out) |->
      !rx_enable_out && !claim_beacon_enable_out;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("receive enabled in init or memory active");

  property p_mode_wr;
    // register lands one edge after the strobe, the output one edge later
    wr_in && addr_in == 4'h0 |-> ##2 mode_out == $past(mfield, 2);
  endproperty
  a_mode_wr: assert property (p_mode_wr)
    else $error("mode field write not reflected");

  property p_online;
    mode_out == 3'h2 && $stable(mode_out) |-> rx_enable_out;
  endproperty
  a_online: assert property (p_online)
    else $error("receive not enabled on line");

  c_take: cover property (tx_word_take_out);
  c_online: cover property (mode_out == 3'h2);
  c_blind_b: cover property (bus_select_in && mode_out == 3'h0);
endmodule // ring_mac_chk

bind ring_mac_tx_path_mode_ctrl ring_mac_chk u_ring_mac_chk (
  .sys_clk_in, .rst_in, .addr_in, .wr_data_in, .wr_in, .bus_select_in,
  .receive_bus_a_in, .receive_bus_b_in, .tx_byte_out, .tx_active_out,
  .tx_word_take_out, .rx_enable_out, .claim_beacon_enable_out, .mode_out
);

// file: phy_ring_model.sv
// far side: drives both receive buses, watches the transmit bytes
module phy_ring_model (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] tx_byte_in,
  output logic      [7:0] bus_a_out,
  output logic      [7:0] bus_b_out,
  output logic      [7:0] idle_run_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;

  // buses change every cycle so a stale mirror never matches
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      bus_a_out <= 8'h00;
      bus_b_out <= 8'h80;
      cnt <= 8'h00;
      idle_run_out <= 8'h00;
    end else begin
      bus_a_out <= bus_a_out + 8'h13;
      bus_b_out <= bus_b_out - 8'h29;
      // idle run length before each start delimiter, saturating
      if (tx_byte_in == 8'hff && cnt != 8'hff) cnt <= cnt + 8'h01;
      else if (tx_byte_in != 8'hff) cnt <= 8'h00;
      if (tx_byte_in == 8'hc5) idle_run_out <= cnt;
    end
  end
endmodule // phy_ring_model

// file: test_ring_mac_tx_path_mode_ctrl.sv
`include "ring_mac_map.vh"
module test_ring_mac_tx_path_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0;
  logic        rst = 1;
  logic [3:0]  addr = 0;
  logic [15:0] wdat = 0;
  logic        wr = 0;
  logic        rd = 0;
  logic [35:0] word = 0;
  logic        wval = 0;
  logic        last = 0;
  logic        tok = 0;
  logic        bsel = 0;
  wire  [15:0] rdat;
  wire  [7:0]  txb, ra, rb, run;
  wire  [2:0]  mode;
  wire         take, act, rxen, cben;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc;
  logic [15:0] v;
  logic [7:0]  e;
  logic [7:0]  exb [4] = '{8'h11, 8'h22, 8'hff, 8'h44};

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;
  // release the word once the design has taken it
  always @(posedge clk) if (take) wval <= 0;

  ring_mac_tx_path_mode_ctrl u_ring_mac_tx_path_mode_ctrl (
    .sys_clk_in(clk), .rst_in(rst), .addr_in(addr), .wr_data_in(wdat),
    .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .tx_word_in(word),
    .tx_word_valid_in(wval), .tx_word_take_out(take),
    .tx_frame_last_in(last), .tx_token_req_in(tok),
    .tx_restricted_in(1'b0), .bus_select_in(bsel),
    .receive_bus_a_in(ra), .receive_bus_b_in(rb), .rx_repeat_in(1'b0),
    .rx_strip_in(1'b0), .rx_ext_copy_in(1'b0), .rx_error_in(1'b0),
    .tx_byte_out(txb), .tx_active_out(act), .rx_enable_out(rxen),
    .claim_beacon_enable_out(cben), .mode_out(mode));

  phy_ring_model u_phy_ring_model (.sys_clk_in(clk), .rst_in(rst),
    .tx_byte_in(txb), .bus_a_out(ra), .bus_b_out(rb), .idle_run_out(run));

  task automatic chk(input string n, input logic [15:0] x, y);
    n_checks++;
    if (x !== y) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, x, y);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    d = rdat;
  endtask

  task automatic wait_byte(input logic [7:0] b);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (txb !== b && i < 300);
    chk("sync", {8'h00, b}, {8'h00, txb});
  endtask

  task automatic finish_test;
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    rreg(`REG_STATUS, v);
    chk("in_init", 16'h0008, v & 16'h0009);
    chk("mode", 16'h0000, {13'h0, mode});
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      bsel <= s[0];
      repeat (2) @(posedge clk);
      @(negedge clk);
      e = s[0] ? rb : ra;
      @(negedge clk);
      chk("blind", {8'h00, e}, {8'h00, txb});
    end
    while (cyc < 240) @(posedge clk);
    rreg(`REG_STATUS, v);
    chk("tvx_run", 16'h0000, v & 16'h0001);
    while (cyc < 275) @(posedge clk);
    rreg(`REG_STATUS, v);
    chk("tvx_exp", 16'h0001, v & 16'h0001);
    wreg(`REG_ADDR_LO, 16'h1234);
    rreg(`REG_ADDR_LO, v);
    chk("addr", 16'h1234, v);
    wreg(`REG_TVX_DEF, 16'h0010);
    wreg(`REG_TVX_LOAD, 16'h0010);
    rreg(`REG_STATUS, v);
    chk("tvx_load", 16'h0000, v & 16'h0001);
    repeat (24) @(posedge clk);
    rreg(`REG_STATUS, v);
    chk("tvx_short", 16'h0001, v & 16'h0001);
    wreg(`REG_MODE_ONE, {1'b0, `MODE_MEM_ACTIVE, 12'h000});
    // mode output follows the register one edge later
    repeat (2) @(negedge clk);
    chk("mode", 16'h0001, {13'h0, mode});
    chk("rx_en", 16'h0000, {15'h0, rxen | cben});
    wreg(`REG_ADDR_LO, 16'h5678);
    rreg(`REG_ADDR_LO, v);
    chk("addr_lock", 16'h1234, v);
    wreg(`REG_MODE_ONE, {1'b0, `MODE_ON_LINE, 12'h000});
    repeat (2) @(negedge clk);
    chk("mode", 16'h0002, {13'h0, mode});
    chk("rx_en", 16'h0001, {15'h0, rxen});
    // parity on the third lane turns that byte into an idle symbol
    @(posedge clk);
    word <= 36'h2_1122_3344;
    last <= 1;
    wval <= 1;
    wait_byte(`SYM_JK);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      chk("data", {8'h00, exb[i]}, {8'h00, txb});
    end
    chk("preamble", 16'h0001, {15'h0, run >= 8'd16});
    repeat (4) @(negedge clk);
    @(negedge clk);
    chk("end_del", {8'h00, `SYM_TS}, {8'h00, txb});
    @(posedge clk);
    tok <= 1;
    wait_byte(`SYM_JK);
    @(posedge clk);
    tok <= 0;
    @(negedge clk);
    chk("token", {8'h00, `SYM_TOKEN_FC}, {8'h00, txb});
    chk("gap", 16'h0001, {15'h0, run >= 8'd16});
    wreg(`REG_MODE_ONE, {1'b0, `MODE_INIT, 12'h000});
    repeat (2) @(negedge clk);
    chk("mode", 16'h0000, {13'h0, mode});
    repeat (3) @(negedge clk);
    chk("tx_idle", 16'h0000, {15'h0, act});
    // host waits eight more cycles after the idle check, then reads an unmapped address
    repeat (8) @(posedge clk);
    rreg(4'hf, v);
    chk("unmapped", 16'h0000, v);
    finish_test();
  end
endmodule // test_ring_mac_tx_path_mode_ctrl
